// [verilog/etp_timer.sv]
// two eight-bit timers with period and pwm modes behind an axi4-lite slave
// Summary of operation
// - the timer clock is chosen from system clock, high rc, low rc, comparator or three pins by control[7:4].
// - control[3:2] routes the first timer to one of three port a pins, the second to port b pins.
// - a selected timer pin is driven with the waveform whatever its direction setting.
// - the chosen clock is prescaled by 1, 4, 16 or 64 per scale[6:5].
// - the prescaled clock is divided again by scale[4:0]+1 to form the timer tick.
// - the eight-bit counter counts up only on each tick and is readable and writable.
// - the counter clears to zero when it reaches the bound in period mode; the bound sets the duty in pwm.
// - each timer works in period mode or in pwm mode with six- or eight-bit resolution.
// - period mode gives a square wave of half duty at clock / (2*(bound+1)*prescale*(scaler+1)).
// - mode set with resolution clear gives pwm of 256 ticks and duty (bound+1)/256.
// - mode set with resolution set gives pwm of 64 ticks and duty (bound+1)/64.
// - with comparator gating on, the pwm output stops while the comparator is high.
// - the second timer has the same structure and behaviour as the first.
// - a timer clocked from the high rc keeps running while the emulator is halted.
`timescale 1ns/1ns
`default_nettype none

module etp_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_HIGH_RC_OSC,
    input wire logic I_LOW_RC_OSC,
    input wire logic I_COMPARATOR,
    input wire logic I_PORT_A_PIN0,
    input wire logic I_PORT_B_PIN0,
    input wire logic I_PORT_A_PIN4,
    input wire logic I_EMULATOR_HALT,
    output logic [2:0] O_PORT_A_PIN_OUT,
    output logic [2:0] O_PORT_A_PIN_OE_N,
    output logic [2:0] O_PORT_B_PIN_OUT,
    output logic [2:0] O_PORT_B_PIN_OE_N,
    output logic O_IRQ
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (ADDR_W < etp_pkg::REG_AW || ADDR_W > 32) begin : g_bad_aw
        $error("ADDR_W must lie between 6 and 32");
    end

    // ****************************************
    // helper functions
    // ****************************************
    // register selector from a byte address, SEL_NONE when unmapped
    function automatic logic [3:0] reg_sel(input logic ok, input logic [etp_pkg::REG_AW-1:0] a);
        logic [3:0] r;
        r = etp_pkg::SEL_NONE;
        if (!ok || a[1:0] != 2'h0) begin
            r = etp_pkg::SEL_NONE;
        end else if (a < etp_pkg::OFS_INT_STATUS) begin
            r = {1'b0, a[4:2]};
        end else if (a == etp_pkg::OFS_INT_STATUS) begin
            r = etp_pkg::SEL_INT_STATUS;
        end else if (a == etp_pkg::OFS_INT_MASK) begin
            r = etp_pkg::SEL_INT_MASK;
        end else if (a == etp_pkg::OFS_GATE) begin
            r = etp_pkg::SEL_GATE;
        end
        return r;
    endfunction

    // level of the chosen clock source
    function automatic logic src_level(input logic [3:0] sel, input logic [5:0] lv);
        logic r;
        r = 1'b0;
        if (sel == etp_pkg::SRC_HIGH_RC) begin
            r = lv[0];
        end else if (sel == etp_pkg::SRC_LOW_RC) begin
            r = lv[1];
        end else if (sel == etp_pkg::SRC_COMPARATOR) begin
            r = lv[2];
        end else if (sel == etp_pkg::SRC_PA0) begin
            r = lv[3];
        end else if (sel == etp_pkg::SRC_PB0) begin
            r = lv[4];
        end else if (sel == etp_pkg::SRC_PA4) begin
            r = lv[5];
        end
        return r;
    endfunction

    // last prescaler count for a divide code
    function automatic logic [5:0] pre_max(input logic [1:0] code);
        logic [5:0] r;
        r = etp_pkg::PRE_MAX_DIV1;
        if (code == 2'h1) begin
            r = etp_pkg::PRE_MAX_DIV4;
        end else if (code == 2'h2) begin
            r = etp_pkg::PRE_MAX_DIV16;
        end else if (code == 2'h3) begin
            r = etp_pkg::PRE_MAX_DIV64;
        end
        return r;
    endfunction

    // one-hot pin of a three-pin group
    function automatic logic [2:0] pin_onehot(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code == etp_pkg::PIN_SEL_A) begin
            r = 3'h2;
        end else if (code == etp_pkg::PIN_SEL_B) begin
            r = 3'h4;
        end else if (code == etp_pkg::PIN_SEL_C) begin
            r = 3'h1;
        end
        return r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    etp_pkg::etp_state_s s;
    etp_pkg::etp_state_s next_s;
    logic [etp_pkg::TIMERS-1:0] tick;
    logic [etp_pkg::TIMERS-1:0] evt;
    logic [etp_pkg::TIMERS-1:0] cnt_wr;
    logic [7:0] cnt_top [etp_pkg::TIMERS];
    logic wr_do;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [3:0] sel;
    logic [5:0] lv;
    logic lvl;
    logic src_hit;
    logic run;
    logic pre_tick;
    logic ti;
    logic lvl_out;
    logic [2:0] oh;
    logic [etp_pkg::TIMERS-1:0] clr;

    // next-state logic for bus, timers, interrupts and pins
    always_comb begin
        next_s = s;
        tick = '0;
        evt = '0;
        cnt_wr = '0;
        clr = '0;
        sel = 4'h0;
        lvl = 1'b0;
        src_hit = 1'b0;
        run = 1'b0;
        pre_tick = 1'b0;
        ti = 1'b0;
        lvl_out = 1'b0;
        oh = 3'h0;
        rsel = etp_pkg::SEL_NONE;
        for (int i = 0; i < etp_pkg::TIMERS; i++) begin
            cnt_top[i] = 8'h00;
        end
        lv = {I_PORT_A_PIN4, I_PORT_B_PIN0, I_PORT_A_PIN0, I_COMPARATOR, I_LOW_RC_OSC, I_HIGH_RC_OSC};

        // write address and data taken in either order
        if (I_AWVALID && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = I_AWADDR[etp_pkg::REG_AW-1:0];
            next_s.aw_ok = (I_AWADDR >> etp_pkg::REG_AW) == '0;
        end
        if (I_WVALID && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_data = I_WDATA;
            next_s.w_strb = I_WSTRB;
        end
        if (s.bvalid && I_BREADY) begin
            next_s.bvalid = 1'b0;
        end
        wr_do = s.aw_full && s.w_full && !s.bvalid;
        wsel = reg_sel(s.aw_ok, s.aw_addr);

        // clock selection, prescaler, scaler and counter per timer
        for (int i = 0; i < etp_pkg::TIMERS; i++) begin
            sel = s.tmr[i].ctrl[7:etp_pkg::CTRL_SRC_LSB];
            lvl = src_level(sel, lv);
            src_hit = (sel == etp_pkg::SRC_SYSCLK) || (lvl && !s.tmr[i].src_q);
            run = !I_EMULATOR_HALT || sel == etp_pkg::SRC_HIGH_RC;
            next_s.tmr[i].src_q = lvl;
            pre_tick = 1'b0;
            if (run && src_hit) begin
                if (s.tmr[i].pre >= pre_max(s.tmr[i].scale[6:etp_pkg::SCALE_PRE_LSB])) begin
                    next_s.tmr[i].pre = 6'h00;
                    pre_tick = 1'b1;
                end else begin
                    next_s.tmr[i].pre = s.tmr[i].pre + 6'h01;
                end
            end
            if (pre_tick) begin
                if (s.tmr[i].scl >= s.tmr[i].scale[4:0]) begin
                    next_s.tmr[i].scl = 5'h00;
                    tick[i] = 1'b1;
                end else begin
                    next_s.tmr[i].scl = s.tmr[i].scl + 5'h01;
                end
            end
            // wrap point: bound in period mode, fixed period in pwm
            if (!s.tmr[i].ctrl[etp_pkg::CTRL_MODE_BIT]) begin
                cnt_top[i] = s.tmr[i].bound;
            end else if (s.tmr[i].scale[etp_pkg::SCALE_RES_BIT]) begin
                cnt_top[i] = etp_pkg::TOP_PWM6;
            end else begin
                cnt_top[i] = etp_pkg::TOP_PWM8;
            end
            if (tick[i]) begin
                if (s.tmr[i].count == cnt_top[i]) begin
                    next_s.tmr[i].count = 8'h00;
                    evt[i] = 1'b1;
                end else begin
                    next_s.tmr[i].count = s.tmr[i].count + 8'h01;
                end
            end
        end

        // register write, software wins over the counter tick
        if (wr_do) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = (wsel == etp_pkg::SEL_NONE) ? etp_pkg::RESP_SLVERR : etp_pkg::RESP_OKAY;
            if (!s.w_strb[0]) begin
                next_s.bresp = next_s.bresp;
            end else if (wsel < etp_pkg::SEL_INT_STATUS) begin
                ti = wsel[2];
                if (wsel[1:0] == etp_pkg::FLD_CTRL) begin
                    next_s.tmr[ti].ctrl = s.w_data[7:0];
                end else if (wsel[1:0] == etp_pkg::FLD_SCALE) begin
                    next_s.tmr[ti].scale = s.w_data[7:0];
                end else if (wsel[1:0] == etp_pkg::FLD_BOUND) begin
                    next_s.tmr[ti].bound = s.w_data[7:0];
                end else begin
                    next_s.tmr[ti].count = s.w_data[7:0];
                    cnt_wr[ti] = 1'b1;
                end
            end else if (wsel == etp_pkg::SEL_INT_STATUS) begin
                clr = s.w_data[etp_pkg::TIMERS-1:0];
            end else if (wsel == etp_pkg::SEL_INT_MASK) begin
                next_s.mask = s.w_data[etp_pkg::TIMERS-1:0];
            end else if (wsel == etp_pkg::SEL_GATE) begin
                next_s.gate = s.w_data[etp_pkg::TIMERS-1:0];
            end
        end

        // register read
        if (s.rvalid && I_RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (I_ARVALID && s.arready) begin
            rsel = reg_sel((I_ARADDR >> etp_pkg::REG_AW) == '0, I_ARADDR[etp_pkg::REG_AW-1:0]);
            next_s.rvalid = 1'b1;
            next_s.rresp = etp_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (rsel < etp_pkg::SEL_INT_STATUS) begin
                ti = rsel[2];
                if (rsel[1:0] == etp_pkg::FLD_CTRL) begin
                    next_s.rdata[7:0] = s.tmr[ti].ctrl;
                end else if (rsel[1:0] == etp_pkg::FLD_SCALE) begin
                    next_s.rdata[7:0] = s.tmr[ti].scale;
                end else if (rsel[1:0] == etp_pkg::FLD_BOUND) begin
                    next_s.rdata[7:0] = s.tmr[ti].bound;
                end else begin
                    next_s.rdata[7:0] = s.tmr[ti].count;
                end
            end else if (rsel == etp_pkg::SEL_INT_STATUS) begin
                next_s.rdata[etp_pkg::TIMERS-1:0] = s.status;
            end else if (rsel == etp_pkg::SEL_INT_MASK) begin
                next_s.rdata[etp_pkg::TIMERS-1:0] = s.mask;
            end else if (rsel == etp_pkg::SEL_GATE) begin
                next_s.rdata[etp_pkg::TIMERS-1:0] = s.gate;
            end else begin
                next_s.rresp = etp_pkg::RESP_SLVERR;
            end
        end

        // waveform and pin routing
        next_s.pa_out = 3'h0;
        next_s.pa_oe_n = 3'h7;
        next_s.pb_out = 3'h0;
        next_s.pb_oe_n = 3'h7;
        for (int i = 0; i < etp_pkg::TIMERS; i++) begin
            if (next_s.tmr[i].ctrl[etp_pkg::CTRL_MODE_BIT]) begin
                next_s.tmr[i].wave = next_s.tmr[i].count <= next_s.tmr[i].bound;
            end else if (evt[i] && !s.tmr[i].ctrl[etp_pkg::CTRL_MODE_BIT]) begin
                next_s.tmr[i].wave = !s.tmr[i].wave;
            end
            lvl_out = next_s.tmr[i].wave
                && !(next_s.gate[i] && I_COMPARATOR && next_s.tmr[i].ctrl[etp_pkg::CTRL_MODE_BIT]);
            oh = pin_onehot(next_s.tmr[i].ctrl[3:etp_pkg::CTRL_PIN_LSB]);
            if (i == 0) begin
                next_s.pa_out = oh & {3{lvl_out}};
                next_s.pa_oe_n = ~oh;
            end else begin
                next_s.pb_out = oh & {3{lvl_out}};
                next_s.pb_oe_n = ~oh;
            end
        end

        // sticky status, set wins over clear
        next_s.status = (s.status & ~clr) | evt;
        next_s.irq = |(next_s.status & next_s.mask);
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // state register
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            s <= '0;
            for (int i = 0; i < etp_pkg::TIMERS; i++) begin
                s.tmr[i].ctrl <= etp_pkg::RST_CTRL;
                s.tmr[i].scale <= etp_pkg::RST_SCALE;
                s.tmr[i].bound <= etp_pkg::RST_BOUND;
                s.tmr[i].count <= etp_pkg::RST_COUNT;
            end
            s.pa_oe_n <= 3'h7;
            s.pb_oe_n <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign O_AWREADY = s.awready;
    assign O_WREADY = s.wready;
    assign O_BVALID = s.bvalid;
    assign O_BRESP = s.bresp;
    assign O_ARREADY = s.arready;
    assign O_RVALID = s.rvalid;
    assign O_RRESP = s.rresp;
    assign O_RDATA = s.rdata;
    assign O_PORT_A_PIN_OUT = s.pa_out;
    assign O_PORT_A_PIN_OE_N = s.pa_oe_n;
    assign O_PORT_B_PIN_OUT = s.pb_out;
    assign O_PORT_B_PIN_OE_N = s.pb_oe_n;
    assign O_IRQ = s.irq;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_full_rate;
        s.tmr[0].ctrl[7:4] == etp_pkg::SRC_SYSCLK && s.tmr[0].scale[6:0] == 7'h00 && !I_EMULATOR_HALT |-> tick[0];
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("no tick at full rate");

    property p_halt_stop;
        I_EMULATOR_HALT && s.tmr[0].ctrl[7:4] != etp_pkg::SRC_HIGH_RC |-> !tick[0];
    endproperty
    a_halt_stop: assert property (p_halt_stop) else $error("tick while halted");

    property p_count_up;
        tick[0] && !cnt_wr[0] && s.tmr[0].count != cnt_top[0] |=> s.tmr[0].count == $past(s.tmr[0].count) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_period_wrap;
        !s.tmr[0].ctrl[1] && tick[0] && !cnt_wr[0] && s.tmr[0].count == s.tmr[0].bound
            |=> s.tmr[0].count == 8'h00 && s.status[0];
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("period wrap missed");

    property p_period_toggle;
        !s.tmr[0].ctrl[1] && evt[0] && !wr_do |=> s.tmr[0].wave != $past(s.tmr[0].wave);
    endproperty
    a_period_toggle: assert property (p_period_toggle) else $error("no toggle at wrap");

    property p_pwm8_wrap;
        s.tmr[0].ctrl[1] && !s.tmr[0].scale[7] && tick[0] && !wr_do && s.tmr[0].count == 8'hff
            |=> s.tmr[0].count == 8'h00;
    endproperty
    a_pwm8_wrap: assert property (p_pwm8_wrap) else $error("8-bit pwm period wrong");

    property p_pwm6_wrap;
        s.tmr[0].ctrl[1] && s.tmr[0].scale[7] && tick[0] && !wr_do && s.tmr[0].count == 8'h3f
            |=> s.tmr[0].count == 8'h00;
    endproperty
    a_pwm6_wrap: assert property (p_pwm6_wrap) else $error("6-bit pwm period wrong");

    property p_pwm_level;
        s.tmr[0].ctrl[1] |-> s.tmr[0].wave == (s.tmr[0].count <= s.tmr[0].bound);
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

    property p_gate;
        s.gate[0] && I_COMPARATOR && s.tmr[0].ctrl[1] && !wr_do |=> O_PORT_A_PIN_OUT == 3'h0;
    endproperty
    a_gate: assert property (p_gate) else $error("pwm not stopped by comparator");

    property p_route;
        s.tmr[0].ctrl[3:2] == etp_pkg::PIN_SEL_B && !s.gate[0] && !wr_do
            |=> !O_PORT_A_PIN_OE_N[2] && O_PORT_A_PIN_OUT[2] == s.tmr[0].wave;
    endproperty
    a_route: assert property (p_route) else $error("timer pin not driven");

    property p_second_wrap;
        !s.tmr[1].ctrl[1] && tick[1] && !cnt_wr[1] && s.tmr[1].count == s.tmr[1].bound
            |=> s.tmr[1].count == 8'h00 ##0 s.status[1];
    endproperty
    a_second_wrap: assert property (p_second_wrap) else $error("second timer wrap missed");

    property p_irq;
        O_IRQ == |(s.status & s.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output wrong");

    c_period_evt: cover property (!s.tmr[0].ctrl[1] && evt[0]);
    c_pwm_wrap: cover property (s.tmr[0].ctrl[1] && evt[0]);
    c_gated: cover property (s.gate[0] && I_COMPARATOR && s.tmr[0].ctrl[1]);
    c_bus_write: cover property (wr_do && wsel != etp_pkg::SEL_NONE);

endmodule

`default_nettype wire

// [verilog/etp_pkg.sv]
// package: register map, field layout, codes and state carriers of the eight-bit timer block
package etp_pkg;

    // ****************************************
    // block size and bus
    // ****************************************
    localparam int TIMERS = 2;
    localparam int REG_AW = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [REG_AW-1:0] OFS_CTRL = 6'h00;
    localparam logic [REG_AW-1:0] OFS_SCALE = 6'h04;
    localparam logic [REG_AW-1:0] OFS_BOUND = 6'h08;
    localparam logic [REG_AW-1:0] OFS_COUNT = 6'h0c;
    localparam logic [REG_AW-1:0] TMR_STRIDE = 6'h10;
    localparam logic [REG_AW-1:0] OFS_INT_STATUS = 6'h20;
    localparam logic [REG_AW-1:0] OFS_INT_MASK = 6'h24;
    localparam logic [REG_AW-1:0] OFS_GATE = 6'h28;

    // decoded register selectors: timer registers are timer*4 + field
    localparam logic [3:0] SEL_INT_STATUS = 4'h8;
    localparam logic [3:0] SEL_INT_MASK = 4'h9;
    localparam logic [3:0] SEL_GATE = 4'ha;
    localparam logic [3:0] SEL_NONE = 4'hf;
    localparam logic [1:0] FLD_CTRL = 2'h0;
    localparam logic [1:0] FLD_SCALE = 2'h1;
    localparam logic [1:0] FLD_BOUND = 2'h2;
    localparam logic [1:0] FLD_COUNT = 2'h3;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_PIN_LSB = 2;
    localparam int CTRL_MODE_BIT = 1;
    localparam int SCALE_RES_BIT = 7;
    localparam int SCALE_PRE_LSB = 5;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_SCALE = 8'h00;
    localparam logic [7:0] RST_BOUND = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // ****************************************
    // clock source, pin and period codes
    // ****************************************
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_SYSCLK = 4'h1;
    localparam logic [3:0] SRC_HIGH_RC = 4'h2;
    localparam logic [3:0] SRC_LOW_RC = 4'h3;
    localparam logic [3:0] SRC_COMPARATOR = 4'h4;
    localparam logic [3:0] SRC_PA0 = 4'h5;
    localparam logic [3:0] SRC_PB0 = 4'h6;
    localparam logic [3:0] SRC_PA4 = 4'h7;
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_SEL_A = 2'h1;
    localparam logic [1:0] PIN_SEL_B = 2'h2;
    localparam logic [1:0] PIN_SEL_C = 2'h3;
    localparam logic [5:0] PRE_MAX_DIV1 = 6'h00;
    localparam logic [5:0] PRE_MAX_DIV4 = 6'h03;
    localparam logic [5:0] PRE_MAX_DIV16 = 6'h0f;
    localparam logic [5:0] PRE_MAX_DIV64 = 6'h3f;
    localparam logic [7:0] TOP_PWM8 = 8'hff;
    localparam logic [7:0] TOP_PWM6 = 8'h3f;

    // ****************************************
    // state carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] scale;
        logic [7:0] bound;
        logic [7:0] count;
        logic [5:0] pre;
        logic [4:0] scl;
        logic src_q;
        logic wave;
    } etp_timer_s;

    typedef struct packed {
        etp_timer_s [TIMERS-1:0] tmr;
        logic [TIMERS-1:0] status;
        logic [TIMERS-1:0] mask;
        logic [TIMERS-1:0] gate;
        logic aw_full;
        logic aw_ok;
        logic [REG_AW-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] pa_out;
        logic [2:0] pa_oe_n;
        logic [2:0] pb_out;
        logic [2:0] pb_oe_n;
        logic irq;
    } etp_state_s;

endpackage

// [sim/etp_far_side.sv]
// far-side model: comparator, high rc oscillator and pin pads
`timescale 1ns/1ns
`default_nettype none
module etp_far_side (
    input wire logic i_clk,
    input wire logic i_cmp_hi,
    input wire logic [5:0] i_out,
    input wire logic [5:0] i_oe_n,
    output logic o_cmp,
    output logic o_hrc,
    output logic [5:0] o_pad
);
    logic hrc_q = 1'b0;
    // high rc runs at half the system clock
    always @(posedge i_clk) hrc_q <= ~hrc_q;
    // released pads fall to their pull-up
    always_comb begin
        o_cmp = i_cmp_hi;
        o_hrc = hrc_q;
        o_pad = (i_out & ~i_oe_n) | i_oe_n;
    end
endmodule
`default_nettype wire

// [sim/etp_timer_test.sv]
// self-checking bench for the eight-bit timer block
`timescale 1ns/1ns
`default_nettype none
module etp_timer_test;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, cmp = 0, halt = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdata;
    logic [1:0] bresp, rresp, rs, wb;
    logic awr, wr_r, bv, arr, rv, irq, hrc, cmpo;
    logic [2:0] pao, paoe, pbo, pboe;
    logic [5:0] pad;
    int errors = 0, checks_done = 0, cyc = 0, hi, tg;
    etp_timer dut (.I_CLK(clk), .I_RESET(rst), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr_r), .O_BRESP(bresp), .O_BVALID(bv),
        .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rresp),
        .O_RVALID(rv), .I_RREADY(rry), .I_HIGH_RC_OSC(hrc), .I_LOW_RC_OSC(1'b0), .I_COMPARATOR(cmpo),
        .I_PORT_A_PIN0(hrc), .I_PORT_B_PIN0(1'b0), .I_PORT_A_PIN4(1'b0), .I_EMULATOR_HALT(halt),
        .O_PORT_A_PIN_OUT(pao), .O_PORT_A_PIN_OE_N(paoe), .O_PORT_B_PIN_OUT(pbo), .O_PORT_B_PIN_OE_N(pboe),
        .O_IRQ(irq));
    etp_far_side far (.i_clk(clk), .i_cmp_hi(cmp), .i_out({pbo, pao}), .i_oe_n({pboe, paoe}),
        .o_cmp(cmpo), .o_hrc(hrc), .o_pad(pad));
    // 125 MHz clock
    always #4 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task report_and_stop;
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            report_and_stop;
        end
    end
    // bus write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        hb = 0;
        while (!hb) begin
            @(negedge clk);
            ha = awv & awr;
            hw = wv & wr_r;
            hb = bv;
            wb = bresp;
            @(posedge clk);
            if (ha) awv <= 0;
            if (hw) wv <= 0;
        end
        bry <= 0;
        @(posedge clk);
    endtask
    // bus read with expected data and response
    task rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string m);
        logic ha, hr;
        ara <= a;
        arv <= 1;
        rry <= 1;
        hr = 0;
        while (!hr) begin
            @(negedge clk);
            ha = arv & arr;
            hr = rv;
            rdata = rd;
            rs = rresp;
            @(posedge clk);
            if (ha) arv <= 0;
        end
        rry <= 0;
        @(posedge clk);
        chk(rdata, exp, m);
        chk({30'h0, rs}, {30'h0, er}, m);
    endtask
    // optional wait for a pad edge, then high cycles and edges over n cycles
    task meas(input int b, input int n, input bit s);
        logic p;
        @(negedge clk);
        p = pad[b];
        while (s && pad[b] == p) @(negedge clk);
        hi = 0;
        tg = 0;
        p = pad[b];
        repeat (n) begin
            @(negedge clk);
            hi += pad[b];
            tg += (pad[b] != p);
            p = pad[b];
        end
        @(posedge clk);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rdr(8'h00, 0, 2'h0, "control reset");
        rdr(8'h0c, 0, 2'h0, "counter reset");
        rdr(8'h30, 0, 2'h2, "unmapped");
        wr(8'h30, 8'h5a);
        chk(wb, 2, "write unmapped");
        wr(8'h08, 8'h01);
        chk(wb, 0, "write okay");
        wr(8'h04, 8'h21);
        wr(8'h00, 8'h18);
        meas(2, 128, 1);
        chk(tg, 8, "period edges");
        chk(hi, 64, "period duty");
        chk(paoe, 3'b011, "pin enable");
        chk(irq, 0, "masked irq");
        rdr(8'h20, 1, 2'h0, "status");
        wr(8'h24, 1);
        chk(irq, 1, "irq");
        wr(8'h00, 0);
        wr(8'h20, 1);
        chk(irq, 0, "irq clear");
        wr(8'h08, 8'h09);
        wr(8'h04, 0);
        wr(8'h00, 8'h1a);
        meas(2, 256, 1);
        chk(hi, 10, "pwm8 duty");
        chk(tg, 2, "pwm8 period");
        wr(8'h04, 8'h80);
        wr(8'h08, 8'h1f);
        wr(8'h0c, 0);
        meas(2, 128, 1);
        chk(hi, 64, "pwm6 duty");
        chk(tg, 4, "pwm6 period");
        wr(8'h28, 1);
        cmp <= 1;
        repeat (3) @(posedge clk);
        meas(2, 128, 0);
        chk(hi, 0, "gated");
        cmp <= 0;
        meas(2, 128, 1);
        chk(hi, 64, "ungated");
        halt <= 1;
        wr(8'h0c, 8'h40);
        repeat (20) @(posedge clk);
        rdr(8'h0c, 8'h40, 2'h0, "halted count");
        wr(8'h18, 8'h01);
        wr(8'h10, 8'h2c);
        meas(3, 64, 1);
        chk(tg, 16, "high rc edges");
        chk(hi, 32, "high rc duty");
        wr(8'h10, 8'h5c);
        meas(3, 64, 0);
        chk(tg, 0, "pin source halted");
        halt <= 0;
        meas(3, 64, 1);
        chk(tg, 16, "pin source edges");
        report_and_stop;
    end
endmodule
`default_nettype wire
